/* File: shared/art_defs.svh */
`ifndef ART_DEFS_SVH
`define ART_DEFS_SVH

// Register offsets on the special function register port
`define ART_OFS_TIMER_CONTROL 8'h88
`define ART_OFS_COUNT_LOW     8'h8a
`define ART_OFS_RELOAD_LOW    8'h8b
`define ART_OFS_COUNT_HIGH    8'h8c
`define ART_OFS_RELOAD_HIGH   8'h8d

// Reset values
`define ART_RST_BYTE          8'h00

// Timer control bit positions
`define ART_BIT_GATE          7
`define ART_BIT_CT            6
`define ART_BIT_OVF           5
`define ART_BIT_RUN           4
`define ART_BIT_IRQ_A_FLAG    3
`define ART_BIT_IRQ_A_TYPE    2
`define ART_BIT_IRQ_B_FLAG    1
`define ART_BIT_IRQ_B_TYPE    0

// Vector acknowledge lanes
`define ART_ACK_IRQ_A         0
`define ART_ACK_TIMER         1
`define ART_ACK_IRQ_B         2

// Machine cycle is twelve oscillator periods
`define ART_MC_DIV            12
`define ART_MC_LAST           4'hb
`define ART_MC_ZERO           4'h0

// Fixed-rate timer
`define ART_FT_ZERO           10'h000
`define ART_FT_LAST           10'h3ff
`define ART_FT_SCL_PRELOAD    10'h003
`define ART_CNT_LAST          16'hffff

`endif

/* File: shared/art_pkg.sv */
package art_pkg;

   typedef struct packed {
      logic [7:0] addr;
      logic       wr;
      logic       rd;
      logic [7:0] wdata;
   } art_sfr_req_s;

   typedef struct packed {
      logic gate;
      logic ct;
      logic ovf;
      logic run;
      logic irq_a_flag;
      logic irq_a_type;
      logic irq_b_flag;
      logic irq_b_type;
   } art_timer_control_s;

   typedef enum logic [2:0] {
      FT_OFF   = 3'b001,
      FT_FREE  = 3'b010,
      FT_WATCH = 3'b100
   } art_ft_mode_e;

endpackage

/* File: logic/art_timer.sv */
`timescale 1ns/1ns
`include "art_defs.svh"

// Notes on behaviour
// - Count source is clock/12 or pin edges
// - Counting only while run bit set
// - 16-bit pair increments per source event
// - Overflow reloads pair from reload registers
// - Reload registers stay unchanged on reload
// - Overflow sets flag; enabled flag requests interrupt
// - External irq a bits 3:2, b bits 1:0
// - External count input is port 1 bit 7
// - Separate 10-bit fixed-rate timer exists
// - Fixed-rate timer ticks once per machine cycle
// - General-purpose timeout every 1024 machine cycles
// - General-purpose use when serial bus unused
// - In frame, bus silence raises lock fault
// - Carry requests interrupt; in frame also resets serial interface
// - Serial clock edges clear; carry 1020-1023 cycles
module art_timer
   import art_pkg::*;
(
   input  wire logic         clock,
   input  wire logic         rst_n,
   input  wire art_sfr_req_s sfr_req,
   output logic [7:0]        sfr_rdata,
   input  wire logic         count_input_pin,
   input  wire logic         ext_irq_a_input,
   input  wire logic         ext_irq_b_input,
   input  wire logic [2:0]   vec_ack,
   input  wire logic         timer_irq_en,
   input  wire logic         serial_en,
   input  wire logic         frame_active,
   input  wire logic         scl_in,
   input  wire logic         ftimer_irq_en,
   input  wire logic         ftimer_ack,
   output logic              timer_irq,
   output logic              ext_irq_a_req,
   output logic              ext_irq_b_req,
   output logic              ftimer_irq,
   output logic              serial_hw_reset
);

   art_timer_control_s    timer_control_ff;
   art_ft_mode_e ft_mode_ff;
   logic [7:0]   count_low_ff;
   logic [7:0]   count_high_ff;
   logic [7:0]   reload_low_ff;
   logic [7:0]   reload_high_ff;
   logic [3:0]   mc_div_ff;
   logic         mc_en_ff;
   logic         pin_prev_ff;
   logic         irq_a_prev_ff;
   logic         irq_b_prev_ff;
   logic         scl_prev_ff;
   logic [9:0]   ft_cnt_ff;
   logic         ft_flag_ff;
   logic [7:0]   sfr_rdata_ff;
   logic         timer_irq_ff;
   logic         ext_irq_a_req_ff;
   logic         ext_irq_b_req_ff;
   logic         ftimer_irq_ff;
   logic         serial_hw_reset_ff;

   logic         wr_timer_control;
   logic         wr_cl;
   logic         wr_ch;
   logic         run_ok;
   logic         src_evt;
   logic         cnt_evt;
   logic         ovf_evt;
   logic [15:0]  count;
   logic [15:0]  nxt_count;
   logic         a_set;
   logic         b_set;
   logic         scl_chg;
   logic         ft_carry;
   art_ft_mode_e nxt_ft_mode;

   assign wr_timer_control = sfr_req.wr && (sfr_req.addr == `ART_OFS_TIMER_CONTROL);
   assign wr_cl   = sfr_req.wr && (sfr_req.addr == `ART_OFS_COUNT_LOW);
   assign wr_ch   = sfr_req.wr && (sfr_req.addr == `ART_OFS_COUNT_HIGH);
   assign count   = {count_high_ff, count_low_ff};

   // Machine cycle enable, one clock in twelve
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         mc_div_ff <= `ART_MC_ZERO;
         mc_en_ff  <= 1'b0;
      end else begin
         mc_div_ff <= (mc_div_ff == `ART_MC_LAST) ? `ART_MC_ZERO : mc_div_ff + 4'h1;
         mc_en_ff  <= (mc_div_ff == `ART_MC_LAST);
      end
   end

   // Previous pin levels for edge detection; pins are already synchronous
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         pin_prev_ff   <= 1'b1;
         irq_a_prev_ff <= 1'b1;
         irq_b_prev_ff <= 1'b1;
         scl_prev_ff   <= 1'b1;
      end else begin
         pin_prev_ff   <= count_input_pin;
         irq_a_prev_ff <= ext_irq_a_input;
         irq_b_prev_ff <= ext_irq_b_input;
         scl_prev_ff   <= scl_in;
      end
   end

   // Counter mode counts falling edges of the pin
   assign src_evt = timer_control_ff.ct ? (pin_prev_ff && !count_input_pin) : mc_en_ff;
   assign run_ok  = timer_control_ff.run && (!timer_control_ff.gate || ext_irq_a_input);
   assign cnt_evt = run_ok && src_evt;
   assign ovf_evt = cnt_evt && (count == `ART_CNT_LAST);

   always_comb begin
      nxt_count = count;
      if (ovf_evt) begin
         nxt_count = {reload_high_ff, reload_low_ff};
      end else if (cnt_evt) begin
         nxt_count = count + 16'h0001;
      end
   end

   // Software writes to the count pair win over the increment
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         count_low_ff  <= `ART_RST_BYTE;
         count_high_ff <= `ART_RST_BYTE;
      end else begin
         count_low_ff  <= wr_cl ? sfr_req.wdata : nxt_count[7:0];
         count_high_ff <= wr_ch ? sfr_req.wdata : nxt_count[15:8];
      end
   end

   // Reload registers change only by software
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         reload_low_ff  <= `ART_RST_BYTE;
         reload_high_ff <= `ART_RST_BYTE;
      end else if (sfr_req.wr) begin
         if (sfr_req.addr == `ART_OFS_RELOAD_LOW) begin
            reload_low_ff <= sfr_req.wdata;
         end
         if (sfr_req.addr == `ART_OFS_RELOAD_HIGH) begin
            reload_high_ff <= sfr_req.wdata;
         end
      end
   end

   // External request flags: falling edge when type set, low level otherwise
   assign a_set = timer_control_ff.irq_a_type ? (irq_a_prev_ff && !ext_irq_a_input) : !ext_irq_a_input;
   assign b_set = timer_control_ff.irq_b_type ? (irq_b_prev_ff && !ext_irq_b_input) : !ext_irq_b_input;

   // Hardware set beats any clear in the same cycle
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         timer_control_ff <= art_timer_control_s'(`ART_RST_BYTE);
      end else begin
         if (wr_timer_control) begin
            timer_control_ff.gate       <= sfr_req.wdata[`ART_BIT_GATE];
            timer_control_ff.ct         <= sfr_req.wdata[`ART_BIT_CT];
            timer_control_ff.run        <= sfr_req.wdata[`ART_BIT_RUN];
            timer_control_ff.irq_a_type <= sfr_req.wdata[`ART_BIT_IRQ_A_TYPE];
            timer_control_ff.irq_b_type <= sfr_req.wdata[`ART_BIT_IRQ_B_TYPE];
         end
         if (ovf_evt) begin
            timer_control_ff.ovf <= 1'b1;
         end else if (vec_ack[`ART_ACK_TIMER]) begin
            timer_control_ff.ovf <= 1'b0;
         end else if (wr_timer_control) begin
            timer_control_ff.ovf <= sfr_req.wdata[`ART_BIT_OVF];
         end
         if (a_set) begin
            timer_control_ff.irq_a_flag <= 1'b1;
         end else if (vec_ack[`ART_ACK_IRQ_A]) begin
            timer_control_ff.irq_a_flag <= 1'b0;
         end else if (wr_timer_control) begin
            timer_control_ff.irq_a_flag <= sfr_req.wdata[`ART_BIT_IRQ_A_FLAG];
         end
         if (b_set) begin
            timer_control_ff.irq_b_flag <= 1'b1;
         end else if (vec_ack[`ART_ACK_IRQ_B]) begin
            timer_control_ff.irq_b_flag <= 1'b0;
         end else if (wr_timer_control) begin
            timer_control_ff.irq_b_flag <= sfr_req.wdata[`ART_BIT_IRQ_B_FLAG];
         end
      end
   end

   // Fixed-rate timer mode follows the serial enable and frame state
   always_comb begin
      if (!serial_en) begin
         nxt_ft_mode = FT_FREE;
      end else if (frame_active) begin
         nxt_ft_mode = FT_WATCH;
      end else begin
         nxt_ft_mode = FT_OFF;
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         ft_mode_ff <= FT_FREE;
      end else begin
         ft_mode_ff <= nxt_ft_mode;
      end
   end

   assign scl_chg  = (scl_prev_ff != scl_in);
   assign ft_carry = mc_en_ff && (ft_cnt_ff == `ART_FT_LAST) && (ft_mode_ff != FT_OFF)
                     && !(ft_mode_ff == FT_WATCH && scl_chg);

   // Preload keeps the watch carry inside the 1020 to 1023 cycle span
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         ft_cnt_ff <= `ART_FT_ZERO;
      end else begin
         case (ft_mode_ff)
            FT_OFF: begin
               ft_cnt_ff <= `ART_FT_ZERO;
            end
            FT_WATCH: begin
               if (scl_chg) begin
                  ft_cnt_ff <= `ART_FT_SCL_PRELOAD;
               end else if (mc_en_ff) begin
                  ft_cnt_ff <= ft_cnt_ff + 10'h001;
               end
            end
            FT_FREE: begin
               if (mc_en_ff) begin
                  ft_cnt_ff <= ft_cnt_ff + 10'h001;
               end
            end
            default: begin
               ft_cnt_ff <= `ART_FT_ZERO;
            end
         endcase
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         ft_flag_ff         <= 1'b0;
         serial_hw_reset_ff <= 1'b0;
      end else begin
         serial_hw_reset_ff <= ft_carry && (ft_mode_ff == FT_WATCH);
         if (ft_carry) begin
            ft_flag_ff <= 1'b1;
         end else if (ftimer_ack) begin
            ft_flag_ff <= 1'b0;
         end
      end
   end

   // Registered requests; timer and fixed-rate requests gated by timer_irq_en and ftimer_irq_en, external requests ungated
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         timer_irq_ff     <= 1'b0;
         ext_irq_a_req_ff <= 1'b0;
         ext_irq_b_req_ff <= 1'b0;
         ftimer_irq_ff    <= 1'b0;
      end else begin
         timer_irq_ff     <= timer_control_ff.ovf && timer_irq_en;
         ext_irq_a_req_ff <= timer_control_ff.irq_a_flag;
         ext_irq_b_req_ff <= timer_control_ff.irq_b_flag;
         ftimer_irq_ff    <= ft_flag_ff && ftimer_irq_en;
      end
   end

   // Read data appears one clock after the read strobe; unmapped reads zero
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         sfr_rdata_ff <= `ART_RST_BYTE;
      end else if (sfr_req.rd) begin
         case (sfr_req.addr)
            `ART_OFS_TIMER_CONTROL: sfr_rdata_ff <= timer_control_ff;
            `ART_OFS_COUNT_LOW:     sfr_rdata_ff <= count_low_ff;
            `ART_OFS_RELOAD_LOW:    sfr_rdata_ff <= reload_low_ff;
            `ART_OFS_COUNT_HIGH:    sfr_rdata_ff <= count_high_ff;
            `ART_OFS_RELOAD_HIGH:   sfr_rdata_ff <= reload_high_ff;
            default:                sfr_rdata_ff <= `ART_RST_BYTE;
         endcase
      end
   end

   assign sfr_rdata       = sfr_rdata_ff;
   assign timer_irq       = timer_irq_ff;
   assign ext_irq_a_req   = ext_irq_a_req_ff;
   assign ext_irq_b_req   = ext_irq_b_req_ff;
   assign ftimer_irq      = ftimer_irq_ff;
   assign serial_hw_reset = serial_hw_reset_ff;

   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);

   AST_MC_DIV: assert property (mc_en_ff |=> !mc_en_ff [*8])
      else $error("Machine cycle enable too frequent");
   AST_SRC_SEL: assert property (timer_control_ff.run && !timer_control_ff.gate && !timer_control_ff.ct
      && !mc_en_ff && !wr_cl && !wr_ch |=> $stable(count))
      else $error("Timer mode counted without machine cycle");
   AST_INC: assert property (cnt_evt && count != `ART_CNT_LAST && !wr_cl && !wr_ch
      |=> count == $past(count) + 16'h0001)
      else $error("Count pair did not increment");
   AST_STOP: assert property (!timer_control_ff.run && !wr_cl && !wr_ch |=> $stable(count))
      else $error("Count moved while stopped");
   AST_GATE: assert property (timer_control_ff.gate && !ext_irq_a_input && !wr_cl && !wr_ch
      |=> $stable(count))
      else $error("Count moved while gated off");
   AST_RELOAD: assert property (ovf_evt && !sfr_req.wr
      |=> count == {reload_high_ff, reload_low_ff} && timer_control_ff.ovf)
      else $error("Overflow did not reload or flag");
   AST_RELOAD_KEEP: assert property (ovf_evt && !sfr_req.wr
      |=> $stable(reload_low_ff) && $stable(reload_high_ff))
      else $error("Reload registers changed on reload");
   AST_TIMER_IRQ: assert property (timer_control_ff.ovf && timer_irq_en |=> timer_irq)
      else $error("Overflow interrupt missing");
   AST_OVF_CLR: assert property (vec_ack[`ART_ACK_TIMER] && !ovf_evt |=> !timer_control_ff.ovf)
      else $error("Vector did not clear overflow flag");
   AST_FT_FREE: assert property (ft_mode_ff == FT_FREE && ft_carry
      |=> ft_cnt_ff == `ART_FT_ZERO && ft_flag_ff)
      else $error("Fixed timer free carry wrong");
   AST_SCL_CLR: assert property (ft_mode_ff == FT_WATCH && scl_chg
      |=> ft_cnt_ff == `ART_FT_SCL_PRELOAD)
      else $error("Serial clock edge did not clear fixed timer");
   AST_SER_RST: assert property (ft_carry && ft_mode_ff == FT_WATCH |=> serial_hw_reset)
      else $error("Lock fault did not reset serial interface");

   COV_OVF: cover property (ovf_evt);
   COV_PIN_EVT: cover property (timer_control_ff.ct && cnt_evt);
   COV_WATCH_CARRY: cover property (ft_carry && ft_mode_ff == FT_WATCH);
   COV_FREE_CARRY: cover property (ft_carry && ft_mode_ff == FT_FREE);

endmodule

/* File: tb/art_pin_src.sv */
`timescale 1ns/1ns
// Count pin source; idles high like a pulled-up port line
module art_pin_src (
   input  wire logic       clock,
   input  wire logic       go,
   input  wire logic [7:0] n,
   output logic            pin
);
   initial begin
      pin = 1'b1;
      forever begin
         @(posedge clock);
         if (go) begin
            // Two clocks low, two high, so the sampler sees every edge
            repeat (n) begin
               pin <= 1'b0;
               repeat (2) @(posedge clock);
               pin <= 1'b1;
               repeat (2) @(posedge clock);
            end
         end
      end
   end
endmodule

/* File: tb/art_timer_tb.sv */
`timescale 1ns/1ns
`include "art_defs.svh"
module art_timer_tb
   import art_pkg::*;
;
   localparam logic [7:0] ctl = `ART_OFS_TIMER_CONTROL;
   localparam logic [7:0] cl  = `ART_OFS_COUNT_LOW;
   localparam logic [7:0] rl  = `ART_OFS_RELOAD_LOW;
   localparam logic [7:0] ch  = `ART_OFS_COUNT_HIGH;
   localparam logic [7:0] rh  = `ART_OFS_RELOAD_HIGH;
   logic         clock, rst_n, count_input_pin, ext_irq_a_input, ext_irq_b_input;
   logic         timer_irq_en, serial_en, frame_active, scl_in, ftimer_irq_en;
   logic         ftimer_ack, timer_irq, ext_irq_a_req, ext_irq_b_req;
   logic         ftimer_irq, serial_hw_reset, src_go;
   logic [7:0]   src_n, sfr_rdata;
   logic [2:0]   vec_ack;
   art_sfr_req_s sfr_req;
   int           error_cnt, samples_checked, k;

   art_timer dut (
      .clock(clock), .rst_n(rst_n), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata),
      .count_input_pin(count_input_pin), .ext_irq_a_input(ext_irq_a_input),
      .ext_irq_b_input(ext_irq_b_input), .vec_ack(vec_ack),
      .timer_irq_en(timer_irq_en), .serial_en(serial_en),
      .frame_active(frame_active), .scl_in(scl_in),
      .ftimer_irq_en(ftimer_irq_en), .ftimer_ack(ftimer_ack),
      .timer_irq(timer_irq), .ext_irq_a_req(ext_irq_a_req),
      .ext_irq_b_req(ext_irq_b_req), .ftimer_irq(ftimer_irq),
      .serial_hw_reset(serial_hw_reset)
   );
   art_pin_src src (.clock(clock), .go(src_go), .n(src_n), .pin(count_input_pin));

   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      samples_checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock);
      sfr_req <= '{a, 1'b1, 1'b0, d};
      @(posedge clock);
      sfr_req.wr <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clock);
      sfr_req <= '{a, 1'b0, 1'b1, 8'h00};
      @(posedge clock);
      sfr_req.rd <= 1'b0;
      @(negedge clock);
      chk($sformatf("reg %h", a), {8'h00, exp}, {8'h00, sfr_rdata});
   endtask

   // Fixed wait covers four clocks per pulse plus the edge sampler lag
   task automatic pulse(input logic [7:0] cnt);
      @(posedge clock);
      src_n <= cnt;
      src_go <= 1'b1;
      @(posedge clock);
      src_go <= 1'b0;
      repeat (4 * cnt + 4) @(posedge clock);
   endtask

   task automatic ft_ack;
      @(posedge clock);
      ftimer_ack <= 1'b1;
      @(posedge clock);
      ftimer_ack <= 1'b0;
   endtask

   task automatic t_regs;
      logic [7:0] ofs [6];
      ofs = '{ctl, cl, rl, ch, rh, 8'h89};
      foreach (ofs[i]) rd(ofs[i], 8'h00);
   endtask

   task automatic t_reload;
      wr(rl, 8'h34);
      wr(rh, 8'h12);
      wr(cl, 8'hfe);
      wr(ch, 8'hff);
      timer_irq_en <= 1'b1;
      wr(ctl, 8'h10);
      k = 0;
      while (timer_irq !== 1'b1 && k < 100) begin
         @(negedge clock);
         k++;
      end
      chk("timer irq", 16'h1, {15'h0, timer_irq});
      // Reads fit before the next machine cycle moves the count
      rd(cl, 8'h34);
      rd(ch, 8'h12);
      rd(rl, 8'h34);
      rd(rh, 8'h12);
      rd(ctl, 8'h30);
      @(posedge clock);
      vec_ack <= 3'b010;
      @(posedge clock);
      vec_ack <= 3'b000;
      rd(ctl, 8'h10);
      wr(ctl, 8'h00);
   endtask

   task automatic t_count;
      wr(cl, 8'h00);
      wr(ch, 8'h00);
      wr(ctl, 8'h40);
      pulse(8'd3);
      rd(cl, 8'h00);
      wr(ctl, 8'h50);
      pulse(8'd5);
      rd(cl, 8'h05);
      @(posedge clock);
      ext_irq_a_input <= 1'b0;
      wr(ctl, 8'hd0);
      pulse(8'd2);
      rd(cl, 8'h05);
      @(posedge clock);
      ext_irq_a_input <= 1'b1;
      pulse(8'd2);
      rd(cl, 8'h07);
      wr(ctl, 8'h00);
   endtask

   task automatic t_ext;
      wr(ctl, 8'h05);
      ext_irq_a_input <= 1'b0;
      repeat (3) @(negedge clock);
      chk("irq a req", 16'h1, {15'h0, ext_irq_a_req});
      rd(ctl, 8'h0d);
      @(posedge clock);
      ext_irq_b_input <= 1'b0;
      repeat (3) @(negedge clock);
      chk("irq b req", 16'h1, {15'h0, ext_irq_b_req});
      rd(ctl, 8'h0f);
      @(posedge clock);
      ext_irq_a_input <= 1'b1;
      ext_irq_b_input <= 1'b1;
      wr(ctl, 8'h00);
      rd(ctl, 8'h00);
   endtask

   task automatic t_free;
      k = 0;
      while (ftimer_irq !== 1'b1 && k < 13000) begin
         @(negedge clock);
         k++;
      end
      ft_ack();
      k = 1;
      while (ftimer_irq !== 1'b0 && k < 13000) begin
         @(negedge clock);
         k++;
      end
      while (ftimer_irq !== 1'b1 && k < 13000) begin
         @(negedge clock);
         k++;
      end
      chk("free period", 16'd12288, k[15:0]);
   endtask

   // Second toggle halfway must restart the span, else carry comes early
   task automatic t_watch;
      ft_ack();
      serial_en <= 1'b1;
      frame_active <= 1'b1;
      repeat (4) @(posedge clock);
      scl_in <= ~scl_in;
      repeat (6000) @(posedge clock);
      scl_in <= ~scl_in;
      k = 0;
      while (serial_hw_reset !== 1'b1 && k < 13000) begin
         @(negedge clock);
         k++;
      end
      chk("watch span", 16'h1, {15'h0, k >= 12240 && k <= 12278});
      repeat (2) @(negedge clock);
      chk("watch irq", 16'h1, {15'h0, ftimer_irq});
   endtask

   task automatic end_of_test;
      $display("checked %0d mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   initial begin
      clock = 1'b0;
      forever #50 clock = ~clock;
   end

   initial begin
      repeat (60000) @(posedge clock);
      error_cnt++;
      end_of_test();
   end

   initial begin
      {rst_n, serial_en, frame_active, scl_in, ftimer_ack, src_go} = '0;
      {ext_irq_a_input, ext_irq_b_input, ftimer_irq_en} = 3'b111;
      {timer_irq_en, vec_ack, src_n} = '0;
      sfr_req = '0;
      error_cnt = 0;
      samples_checked = 0;
      repeat (2) @(posedge clock);
      rst_n <= 1'b1;
      t_regs();
      t_reload();
      t_count();
      t_ext();
      t_free();
      t_watch();
      end_of_test();
   end
endmodule
